// *** flash_block_protect_ctrl.sv ***
`timescale 1ns/1ps
// How it works
// - addresses from derived start up to FFFF are protected.
// - high voltage enable refused when target is protected.
// - 00 protects everything, FF protects nothing.
// - values other than FF/FE lock the protect byte and block.
// - whole-array erase disabled unless protect byte is FF.
// - test bypass voltage on interrupt pin ignores protection.
// - protect byte erased by page or mass erase when unprotected.
// - protect byte lives in flash, survives reset, factory value FF.
// - start address is 11, protect bits, six zeros.
// - FD starts at FF40, FE starts at FF80.
// - wait or stop in read mode leaves flash untouched.
// - wait or stop mid-operation abandons it into standby.
// - standby holds all flash control signals inactive.
// - program and erase select never both one.
// - high voltage turns on only with a select and proper sequence; a later write keeping its bit holds it with no select.
// - whole-array bit picks mass erase, else 64-byte page.
// - program cycle is one 32-byte row; cross-row writes fail.
module flash_block_protect_ctrl
   import flash_guard_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        RST,
   input  wire logic [3:0]  ADDR,
   input  wire logic [7:0]  WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [7:0]  RDATA,
   input  wire logic        FLASH_WR,
   input  wire logic [15:0] FLASH_ADDR,
   input  wire logic [7:0]  FLASH_DATA,
   input  wire logic        TEST_BYPASS_VOLTAGE,
   input  wire logic        WAIT_MODE,
   input  wire logic        STOP_MODE,
   output logic             HIGH_VOLTAGE_ENABLE,
   output logic             PROGRAM_SELECT,
   output logic             ERASE_SELECT,
   output logic             MASS_SELECT,
   output logic             PROG_STROBE,
   output logic      [15:0] PROG_ADDR,
   output logic      [7:0]  PROG_DATA,
   output logic             PAGE_ERASE,
   output logic             MASS_ERASE,
   output logic             STANDBY,
   output logic      [7:0]  PROTECT_START_BYTE
);

   // ****************************************************************
   // state
   // ****************************************************************
   logic        pgm_reg;
   logic        erase_reg;
   logic        mass_reg;
   logic        high_voltage_enable_reg;
   seq_type     seq_reg;
   logic [15:0] target_reg;
   logic [7:0]  sample_reg;
   logic        refused_reg;
   logic        row_fail_reg;
   logic        standby_reg;
   logic        protect_read_reg;
   logic [7:0]  protect_store_reg;
   // starts low once at power-up only; reset must not reload the store
   logic        store_init_reg = 1'b0;
   logic [7:0]  rdata_reg;

   logic        ctrl_wr;
   logic        low_power;
   logic        is_protected;
   logic        mass_blocked;
   logic        high_voltage_enable_req;
   logic        high_voltage_enable_ok;
   logic        gap_expired;
   logic        in_flash;
   logic [7:0]  protect_now;

   assign ctrl_wr   = WR && (ADDR == CTRL_OFFSET);
   assign low_power = WAIT_MODE || STOP_MODE;
   assign in_flash  = (FLASH_ADDR >= FLASH_BASE)
                      && !((FLASH_ADDR >= RESV_LO)
                      && (FLASH_ADDR <= RESV_HI));
   assign protect_now = store_init_reg ? protect_store_reg : PROTECT_RESET;

   protect_compare u_compare (
      .protect_bits (sample_reg),
      .target       (target_reg),
      .bypass       (TEST_BYPASS_VOLTAGE),
      .is_protected (is_protected),
      .mass_blocked (mass_blocked)
   );

   row_timer u_timer (
      .CLOCK   (CLOCK),
      .RST     (RST),
      .restart (FLASH_WR),
      .run     (high_voltage_enable_reg && pgm_reg),
      .expired (gap_expired)
   );

   // ****************************************************************
   // select bits
   // ****************************************************************
   always_ff @(posedge CLOCK) begin
      if (RST || (low_power && (pgm_reg || erase_reg))) begin
         pgm_reg   <= 1'b0;
         erase_reg <= 1'b0;
         mass_reg  <= 1'b0;
      end else if (ctrl_wr) begin
         // a request for both selects leaves both select bits unchanged; mass still loads
         if (!(WDATA[PGM_BIT] && WDATA[ERASE_BIT])) begin
            pgm_reg   <= WDATA[PGM_BIT] && !erase_reg;
            erase_reg <= WDATA[ERASE_BIT] && !pgm_reg;
         end
         mass_reg <= WDATA[MASS_BIT];
      end
   end

   // ****************************************************************
   // sequence tracking
   // ****************************************************************
   always_ff @(posedge CLOCK) begin
      if (RST || low_power) begin
         seq_reg          <= SEQ_IDLE;
         protect_read_reg <= 1'b0;
         target_reg       <= 16'h0000;
      end else begin
         if (RD && (ADDR == PROTECT_OFFSET)) begin
            protect_read_reg <= 1'b1;
         end
         case (seq_reg)
            SEQ_IDLE: begin
               if (pgm_reg || erase_reg) begin
                  seq_reg          <= SEQ_ARMED;
                  protect_read_reg <= 1'b0;
               end
            end
            SEQ_ARMED: begin
               if (!pgm_reg && !erase_reg) begin
                  seq_reg <= SEQ_IDLE;
               end else if (FLASH_WR && in_flash) begin
                  target_reg <= FLASH_ADDR;
                  seq_reg    <= SEQ_LATCHED;
               end
            end
            SEQ_LATCHED: begin
               if (!pgm_reg && !erase_reg) begin
                  seq_reg <= SEQ_IDLE;
               end else if (high_voltage_enable_reg) begin
                  seq_reg <= SEQ_HIGH;
               end
            end
            SEQ_HIGH: begin
               if (!high_voltage_enable_reg) begin
                  seq_reg <= SEQ_IDLE;
               end
            end
            default: seq_reg <= SEQ_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // protect byte sample and high voltage gate
   // ****************************************************************
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         sample_reg <= PROTECT_RESET;
      end else if (RD && (ADDR == PROTECT_OFFSET)) begin
         sample_reg <= protect_now;
      end
   end

   assign high_voltage_enable_req = ctrl_wr && WDATA[HIGH_VOLTAGE_ENABLE_BIT] && !high_voltage_enable_reg;
   // mass erase also needs no block protected
   assign high_voltage_enable_ok  = (pgm_reg || erase_reg)
                     && (seq_reg == SEQ_LATCHED) && protect_read_reg
                     && !is_protected
                     && !(erase_reg && mass_reg && mass_blocked);

   always_ff @(posedge CLOCK) begin
      if (RST || low_power) begin
         high_voltage_enable_reg <= 1'b0;
      end else if (ctrl_wr) begin
         high_voltage_enable_reg <= WDATA[HIGH_VOLTAGE_ENABLE_BIT] && (high_voltage_enable_reg || high_voltage_enable_ok);
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST || ctrl_wr && WDATA[HIGH_VOLTAGE_ENABLE_BIT] && high_voltage_enable_ok) begin
         refused_reg <= 1'b0;
      end else if (high_voltage_enable_req && !high_voltage_enable_ok) begin
         refused_reg <= 1'b1;
      end
   end

   // ****************************************************************
   // row programming, cross-row writes fail
   // ****************************************************************
   always_ff @(posedge CLOCK) begin
      if (RST || (seq_reg == SEQ_IDLE)) begin
         row_fail_reg <= 1'b0;
      end else if (FLASH_WR && high_voltage_enable_reg && pgm_reg
                   && (FLASH_ADDR[15:ROW_LSB] != target_reg[15:ROW_LSB])) begin
         row_fail_reg <= 1'b1;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         PROG_STROBE <= 1'b0;
         PROG_ADDR   <= 16'h0000;
         PROG_DATA   <= 8'h00;
      end else begin
         PROG_STROBE <= FLASH_WR && high_voltage_enable_reg && pgm_reg && !low_power
                        && !row_fail_reg && in_flash
                        && (FLASH_ADDR[15:ROW_LSB]
                        == target_reg[15:ROW_LSB]);
         PROG_ADDR   <= FLASH_ADDR;
         PROG_DATA   <= FLASH_DATA;
      end
   end

   // ****************************************************************
   // model of the stored protect byte; not touched by reset
   // ****************************************************************
   always_ff @(posedge CLOCK) begin
      if (!store_init_reg) begin
         protect_store_reg <= PROTECT_RESET;
      end else if (PROG_STROBE && (PROG_ADDR == PROTECT_BYTE_ADDR)) begin
         protect_store_reg <= protect_store_reg & PROG_DATA;
      end else if (MASS_ERASE || (PAGE_ERASE
                   && target_reg[15:PAGE_LSB]
                   == PROTECT_BYTE_ADDR[15:PAGE_LSB])) begin
         protect_store_reg <= PROTECT_RESET;
      end
   end

   always_ff @(posedge CLOCK) begin
      store_init_reg <= 1'b1;
   end

   // ****************************************************************
   // erase pulses and standby
   // ****************************************************************
   always_ff @(posedge CLOCK) begin
      if (RST || low_power) begin
         PAGE_ERASE <= 1'b0;
         MASS_ERASE <= 1'b0;
      end else begin
         PAGE_ERASE <= high_voltage_enable_reg && erase_reg && !mass_reg;
         MASS_ERASE <= high_voltage_enable_reg && erase_reg && mass_reg;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         standby_reg <= 1'b0;
      end else if (low_power && (pgm_reg || erase_reg || high_voltage_enable_reg)) begin
         standby_reg <= 1'b1;
      end else if (!low_power) begin
         standby_reg <= 1'b0;
      end
   end

   // standby forces every array control low
   assign HIGH_VOLTAGE_ENABLE = high_voltage_enable_reg && !standby_reg;
   assign PROGRAM_SELECT      = pgm_reg && !standby_reg;
   assign ERASE_SELECT        = erase_reg && !standby_reg;
   assign MASS_SELECT         = mass_reg && !standby_reg;
   assign STANDBY             = standby_reg;
   assign PROTECT_START_BYTE  = protect_now;

   // ****************************************************************
   // register read
   // ****************************************************************
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         rdata_reg <= 8'h00;
      end else if (RD) begin
         case (ADDR)
            CTRL_OFFSET:    rdata_reg <= {4'h0, high_voltage_enable_reg, mass_reg,
                                          erase_reg, pgm_reg};
            PROTECT_OFFSET: rdata_reg <= protect_now;
            STATUS_OFFSET:  rdata_reg <= {3'h0, gap_expired, standby_reg,
                                          row_fail_reg, refused_reg,
                                          is_protected};
            ADDR_LO_OFFSET: rdata_reg <= target_reg[7:0];
            ADDR_HI_OFFSET: rdata_reg <= target_reg[15:8];
            default:        rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign RDATA = rdata_reg;

   // ****************************************************************
   // checks
   // ****************************************************************
   chk_select_interlock: assert property (@(posedge CLOCK) disable iff (RST)
      !(pgm_reg && erase_reg)) else $error("program and erase both set");
   chk_high_voltage_enable_protected: assert property (@(posedge CLOCK) disable iff (RST)
      (high_voltage_enable_req && is_protected) |=> !high_voltage_enable_reg)
      else $error("high voltage set on protected target");
   chk_high_voltage_enable_select: assert property (@(posedge CLOCK) disable iff (RST)
      $rose(high_voltage_enable_reg) |-> $past(pgm_reg || erase_reg))
      else $error("high voltage without select");
   chk_mass_block: assert property (@(posedge CLOCK) disable iff (RST)
      (high_voltage_enable_req && erase_reg && mass_reg && mass_blocked) |=> !high_voltage_enable_reg)
      else $error("mass erase while protected");
   chk_standby_quiet: assert property (@(posedge CLOCK) disable iff (RST)
      STANDBY |-> !(HIGH_VOLTAGE_ENABLE || PROGRAM_SELECT || ERASE_SELECT))
      else $error("controls active in standby");
   chk_abandon_op: assert property (@(posedge CLOCK) disable iff (RST)
      (low_power && (pgm_reg || erase_reg))
      |=> (!pgm_reg && !erase_reg && !high_voltage_enable_reg && STANDBY))
      else $error("operation not abandoned");
   chk_row_only: assert property (@(posedge CLOCK) disable iff (RST)
      PROG_STROBE |-> (PROG_ADDR[15:ROW_LSB] == target_reg[15:ROW_LSB]))
      else $error("program outside latched row");
   chk_all_zero: assert property (@(posedge CLOCK) disable iff (RST)
      (sample_reg == PROTECT_ALL && !TEST_BYPASS_VOLTAGE) |-> is_protected)
      else $error("zero protect byte left open");
endmodule // flash_block_protect_ctrl

// *** flash_guard_pkg.sv ***
package flash_guard_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [3:0] CTRL_OFFSET    = 4'h0;
   localparam logic [3:0] PROTECT_OFFSET = 4'h1;
   localparam logic [3:0] STATUS_OFFSET  = 4'h2;
   localparam logic [3:0] ADDR_LO_OFFSET = 4'h3;
   localparam logic [3:0] ADDR_HI_OFFSET = 4'h4;

   // ****************************************************************
   // control field positions
   // ****************************************************************
   localparam int PGM_BIT   = 0;
   localparam int ERASE_BIT = 1;
   localparam int MASS_BIT  = 2;
   localparam int HIGH_VOLTAGE_ENABLE_BIT  = 3;

   // ****************************************************************
   // protect byte encoding
   // ****************************************************************
   localparam logic [7:0]  PROTECT_RESET    = 8'hff;
   localparam logic [7:0]  PROTECT_NONE     = 8'hff;
   localparam logic [7:0]  PROTECT_VECTORS  = 8'hfe;
   localparam logic [7:0]  PROTECT_ALL      = 8'h00;
   localparam logic [15:0] PROTECT_BYTE_ADDR = 16'hff7e;
   localparam logic [15:0] FLASH_TOP        = 16'hffff;
   localparam logic [15:0] FLASH_BASE       = 16'hc000;
   localparam logic [15:0] RESV_LO          = 16'hffd4;
   localparam logic [15:0] RESV_HI          = 16'hffdf;
   localparam int          ROW_LSB          = 5;
   localparam int          PAGE_LSB         = 6;
   localparam int          ROW_BYTES        = 32;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLOCK_MHZ        = 40;
   localparam int PROG_MAX_US      = 40;
   localparam int PROG_MAX_CYCLES  = PROG_MAX_US * CLOCK_MHZ;

   typedef enum logic [1:0] {
      SEQ_IDLE, SEQ_ARMED, SEQ_LATCHED, SEQ_HIGH
   } seq_type;

   // 16-bit start address from the eight protect bits
   function automatic logic [15:0] start_of(input logic [7:0] bits);
      start_of = {2'b11, bits, 6'b00_0000};
   endfunction

endpackage

// *** protect_compare.sv ***
`timescale 1ns/1ps
module protect_compare
   import flash_guard_pkg::*;
(
   input  wire logic [7:0]  protect_bits,
   input  wire logic [15:0] target,
   input  wire logic        bypass,
   output logic             is_protected,
   output logic             mass_blocked
);
   logic [15:0] start_addr;

   assign start_addr   = start_of(protect_bits);
   // all ones leaves everything open; zero start covers the whole array
   assign is_protected = !bypass && (protect_bits != PROTECT_NONE)
                         && ((protect_bits == PROTECT_ALL)
                         || (target >= start_addr));
   assign mass_blocked = !bypass && (protect_bits != PROTECT_NONE);
endmodule // protect_compare

// *** row_timer.sv ***
`timescale 1ns/1ps
module row_timer
   import flash_guard_pkg::*;
(
   input  wire logic CLOCK,
   input  wire logic RST,
   input  wire logic restart,
   input  wire logic run,
   output logic      expired
);
   logic [15:0] count_reg;

   // ****************************************************************
   // gap between byte writes, informational only
   // ****************************************************************
   always_ff @(posedge CLOCK) begin
      if (RST || restart || !run) begin
         count_reg <= 16'h0000;
      end else if (count_reg != 16'(PROG_MAX_CYCLES)) begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   assign expired = (count_reg == 16'(PROG_MAX_CYCLES));
endmodule // row_timer

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
   import flash_guard_pkg::*;

   // ****************************************************************
   // signals
   // ****************************************************************
   logic        CLOCK, RST, WR, RD, FLASH_WR, TEST_BYPASS_VOLTAGE;
   logic        WAIT_MODE, STOP_MODE, HIGH_VOLTAGE_ENABLE, PROGRAM_SELECT;
   logic        ERASE_SELECT, MASS_SELECT, PROG_STROBE, PAGE_ERASE;
   logic        MASS_ERASE, STANDBY;
   logic [3:0]  ADDR;
   logic [7:0]  WDATA, RDATA, FLASH_DATA, PROG_DATA, PROTECT_START_BYTE;
   logic [15:0] FLASH_ADDR, PROG_ADDR;
   int          err_count, n_tests, cycles;
   integer      seed;
   logic [7:0]  cur, v, d;
   logic [15:0] tg[5];
   logic [7:0]  corner[5] = '{8'h00, 8'hfd, 8'hfe, 8'hfc, 8'h01};

   flash_block_protect_ctrl flash_block_protect_ctrl_inst (.*);

   initial begin
      CLOCK = 1'b0;
      forever #12.5 CLOCK = ~CLOCK;
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // generous ceiling: the whole run needs well under two thousand cycles
   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         conclude();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick;
      @(posedge CLOCK);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] dat);
      @(posedge CLOCK);
      ADDR  <= a;
      WDATA <= dat;
      WR    <= 1'b1;
      @(posedge CLOCK);
      WR    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] dat);
      @(posedge CLOCK);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge CLOCK);
      RD   <= 1'b0;
      #1;
      dat = RDATA;
   endtask

   task automatic fw(input logic [15:0] a, input logic [7:0] dat);
      @(posedge CLOCK);
      FLASH_ADDR <= a;
      FLASH_DATA <= dat;
      FLASH_WR   <= 1'b1;
      @(posedge CLOCK);
      FLASH_WR   <= 1'b0;
      #1;
   endtask

   function automatic logic prot(input logic [7:0] b, input logic [15:0] t);
      return (b != 8'hff) && ((b == 8'h00) || (t >= {2'b11, b, 6'h00}));
   endfunction

   // select, protect read, latch target, then ask for high voltage
   task automatic op(input logic [7:0] sel, input logic [15:0] t,
                     input logic exp);
      logic [7:0] r;
      wr(CTRL_OFFSET, sel);
      rd(PROTECT_OFFSET, r);
      check(r, cur);
      fw(t, 8'hff);
      wr(CTRL_OFFSET, sel | 8'h08);
      tick();
      check(HIGH_VOLTAGE_ENABLE, exp);
   endtask

   task automatic prog(input logic [15:0] t, input logic [7:0] dat,
                       input logic exp);
      op(8'h01, t, exp);
      fw(t, dat);
      check(PROG_STROBE, exp);
      if (exp) begin
         check({PROG_ADDR}, t);
         check(PROG_DATA, dat);
      end
      wr(CTRL_OFFSET, 8'h00);
   endtask

   task automatic erase(input logic [7:0] sel, input logic [15:0] t,
                        input logic exp);
      op(sel, t, exp);
      check({MASS_ERASE, PAGE_ERASE}, exp ? {sel[2], ~sel[2]} : 2'b00);
      wr(CTRL_OFFSET, 8'h00);
      tick();
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      seed = 32'h392e7543;
      {RST, WR, RD, FLASH_WR, TEST_BYPASS_VOLTAGE, WAIT_MODE, STOP_MODE} = 7'h40;
      ADDR = 4'h0;
      WDATA = 8'h00;
      FLASH_DATA = 8'h00;
      FLASH_ADDR = 16'h0000;
      cur = 8'hff;
      repeat (4) @(posedge CLOCK);
      RST <= 1'b0;
      tick();
      check(PROTECT_START_BYTE, 8'hff);
      wr(CTRL_OFFSET, 8'h03);
      tick();
      check({PROGRAM_SELECT, ERASE_SELECT}, 2'b00);
      wr(CTRL_OFFSET, 8'h01);
      wr(CTRL_OFFSET, 8'h03);
      tick();
      check({PROGRAM_SELECT, ERASE_SELECT}, 2'b10);
      wr(CTRL_OFFSET, 8'h00);
      wr(CTRL_OFFSET, 8'h08);
      tick();
      check(HIGH_VOLTAGE_ENABLE, 1'b0);
      rd(STATUS_OFFSET, d);
      check(d[1], 1'b1);
      // protect read skipped on purpose
      wr(CTRL_OFFSET, 8'h01);
      fw(16'hc000, 8'hff);
      wr(CTRL_OFFSET, 8'h09);
      tick();
      check(HIGH_VOLTAGE_ENABLE, 1'b0);
      wr(CTRL_OFFSET, 8'h00);
      $display("test interlock done");
      erase(8'h06, 16'hc000, 1'b1);
      erase(8'h02, 16'hc040, 1'b1);
      op(8'h01, 16'hc100, 1'b1);
      fw(16'hc100, 8'h11);
      fw(16'hc120, 8'h22);
      rd(STATUS_OFFSET, d);
      check(d[2], 1'b1);
      wr(CTRL_OFFSET, 8'h00);
      $display("test erase and row done");
      prog(PROTECT_BYTE_ADDR, 8'hfe, 1'b1);
      cur = 8'hfe;
      check(PROTECT_START_BYTE, 8'hfe);
      @(posedge CLOCK);
      WAIT_MODE <= 1'b1;
      repeat (2) tick();
      check(STANDBY, 1'b0);
      @(posedge CLOCK);
      WAIT_MODE <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         op(8'h02, 16'hc040, 1'b1);
         @(posedge CLOCK);
         WAIT_MODE <= (i == 0);
         STOP_MODE <= (i == 1);
         repeat (2) tick();
         check({STANDBY, HIGH_VOLTAGE_ENABLE, PROGRAM_SELECT, ERASE_SELECT,
                MASS_SELECT, PAGE_ERASE, MASS_ERASE}, 7'h40);
         @(posedge CLOCK);
         {WAIT_MODE, STOP_MODE} <= 2'b00;
         wr(CTRL_OFFSET, 8'h00);
      end
      // a second reset must leave the stored byte alone
      @(posedge CLOCK);
      RST <= 1'b1;
      @(posedge CLOCK);
      RST <= 1'b0;
      tick();
      check(PROTECT_START_BYTE, 8'hfe);
      check(STANDBY, 1'b0);
      $display("test low power done");
      for (int k = 0; k < 13; k++) begin
         v = (k < 5) ? corner[k] : 8'($random(seed));
         prog(PROTECT_BYTE_ADDR, v, 1'b1);
         cur = v;
         check(PROTECT_START_BYTE, v);
         tg[0] = {2'b11, v, 6'h00};
         tg[1] = (v == 8'h00) ? 16'hc000 : tg[0] - 16'h0001;
         tg[2] = PROTECT_BYTE_ADDR;
         tg[3] = 16'hffff;
         tg[4] = {2'b11, 14'($random(seed))};
         if (tg[4] >= RESV_LO && tg[4] <= RESV_HI) begin
            tg[4] = FLASH_BASE;
         end
         for (int j = 0; j < 5; j++) begin
            op(8'h01, tg[j], ~prot(v, tg[j]));
            wr(CTRL_OFFSET, 8'h00);
         end
         erase(8'h06, 16'hc000, v == 8'hff);
         if (v == 8'hfe) begin
            erase(8'h02, 16'hff40, 1'b1);
         end else begin
            @(posedge CLOCK);
            TEST_BYPASS_VOLTAGE <= 1'b1;
            op(8'h01, tg[0], 1'b1);
            wr(CTRL_OFFSET, 8'h00);
            erase(8'h06, 16'hc000, 1'b1);
            @(posedge CLOCK);
            TEST_BYPASS_VOLTAGE <= 1'b0;
         end
         cur = 8'hff;
         check(PROTECT_START_BYTE, 8'hff);
         $display("test protect value %h done", v);
      end
      conclude();
   end

endmodule // testbench
